// ---- pkg/abcx_pkg.sv ----
`default_nettype none
package abcx_pkg;

  // ---------------------------------------------------------------
  // opcode fields
  // ---------------------------------------------------------------
  localparam logic [4:0]  CALL_LOW5      = 5'h11;
  localparam logic [4:0]  JUMP_LOW5      = 5'h01;
  localparam logic [3:0]  ADD_HI_NIB     = 4'h2;
  localparam logic [3:0]  CARRY_HI_NIB   = 4'h3;
  localparam logic [3:0]  FORM_IMM       = 4'h4;
  localparam logic [3:0]  FORM_DIRECT    = 4'h5;
  localparam logic [2:0]  FORM_IND_HI3   = 3'h3;
  localparam int          CARRY_SEL_BIT  = 4;
  localparam int          SPACE_BIT      = 7;

  // ---------------------------------------------------------------
  // reset values and cycle counts
  // ---------------------------------------------------------------
  localparam logic [15:0] PC_RESET       = 16'h0000;
  localparam logic [7:0]  SP_RESET       = 8'h07;
  localparam logic [7:0]  ACC_RESET      = 8'h00;
  localparam logic [1:0]  PAGE_CYCLES    = 2'h2;
  localparam logic [1:0]  ADD_CYCLES     = 2'h1;
  localparam logic [1:0]  OTHER_CYCLES   = 2'h1;
  localparam logic [1:0]  ELAPSED_MAX    = 2'h3;
  localparam int          MC_CLKS_DEF    = 12;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic       cy;
    logic       auxiliary_carry_flag;
    logic       f0;
    logic [1:0] bank;
    logic       signed_overflow_flag;
    logic       f1;
    logic       parity;
  } abcx_psw_t;

  localparam abcx_psw_t PSW_RESET = '0;

  typedef struct packed {
    logic        special_function_space;
    logic [7:0]  bit_byte;
    logic [2:0]  bit_pos;
    logic [15:0] rel_target;
  } abcx_arg_view_t;

  typedef logic [7:0]  abcx_immediate_byte_t;
  typedef logic [15:0] abcx_immediate_word_t;
  typedef logic [15:0] abcx_full_code_address_t;

  // ---------------------------------------------------------------
  // decode helpers
  // ---------------------------------------------------------------
  function automatic logic is_page_call(input logic [7:0] op);
    return op[4:0] == CALL_LOW5;
  endfunction

  function automatic logic is_page_jump(input logic [7:0] op);
    return op[4:0] == JUMP_LOW5;
  endfunction

  function automatic logic is_add(input logic [7:0] op);
    return (op[7:4] == ADD_HI_NIB || op[7:4] == CARRY_HI_NIB) && op[3:2] != 2'h0;
  endfunction

  // eleven bits replaced; the 2k block of the following byte is kept
  function automatic abcx_full_code_address_t page_target_address(
      input logic [15:0] pc, input logic [7:0] op, input logic [7:0] arg);
    return {pc[15:11], op[7:5], arg};
  endfunction

  function automatic abcx_full_code_address_t rel_target(
      input logic [15:0] pc, input logic [7:0] disp);
    return 16'(pc + {{8{disp[7]}}, disp});
  endfunction

  // selectors below the midpoint live in internal data memory
  function automatic logic direct_is_special(input logic [7:0] a);
    return a[SPACE_BIT];
  endfunction

  function automatic logic [7:0] bit_byte_of(input logic [7:0] bit_selector);
    return bit_selector[7] ? {bit_selector[7:3], 3'h0} : {4'h2, bit_selector[6:3]};
  endfunction

endpackage
`default_nettype wire

// ---- hw/abcx_add_unit.sv ----
`default_nettype none
module abcx_add_unit (
  input  wire logic [7:0] a,
  input  wire logic [7:0] b,
  input  wire logic       cin,
  input  wire logic       with_carry,
  output logic      [7:0] sum,
  output logic            cy,
  output logic            aux,
  output logic            ovf
);
  logic       c_in;
  logic [4:0] lo4;
  logic [7:0] lo7;
  logic [8:0] full;

  // RULE_11: carry in only for the carry form
  assign c_in = with_carry & cin;
  assign lo4  = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, c_in};
  assign lo7  = {1'b0, a[6:0]} + {1'b0, b[6:0]} + {7'h00, c_in};
  assign full = {1'b0, a} + {1'b0, b} + {8'h00, c_in};
  assign sum  = full[7:0];
  // RULE_12: carry out of bit 7
  assign cy   = full[8];
  // RULE_13: carry out of bit 3
  assign aux  = lo4[4];
  // RULE_14: carries out of bit 6 and 7 differ
  assign ovf  = lo7[7] ^ full[8];
endmodule
`default_nettype wire

// ---- hw/abcx_core.sv ----
// Contract
// RULE_01: opcode is one full byte; length counts it; time in machine cycles.
// RULE_02: a bit operand byte selects one of 256 bits.
// RULE_03: direct byte below 0x80 is internal memory, above is special space.
// RULE_04: relative operand is a signed byte displacement from next instruction.
// RULE_05: short immediate one byte, long immediate and code address sixteen bits.
// RULE_06: low five bits 10001 is page call; two bytes, two cycles, no flags.
// RULE_07: call pushes next address low byte then high byte, then redirects.
// RULE_08: target low byte from second byte, high bits 0-2 from opcode 5-7.
// RULE_09: call target stays in the 2k block following the call.
// RULE_10: add results go to accumulator; source operand untouched.
// RULE_11: carry form adds carry flag; plain add ignores it.
// RULE_12: carry flag set when unsigned sum exceeds 255, else cleared.
// RULE_13: auxiliary carry set when low nibble sum exceeds 15, else cleared.
// RULE_14: overflow set when carries out of bits 6 and 7 differ.
// RULE_15: add at 0x24-0x2F, carry form at 0x34-0x3F, low nibble picks operand.
// RULE_16: only listed flags change; others keep their values.
// RULE_17: page jump forms target like call, pushes nothing; low five 00001.
// RULE_18: stack pointer increments before each pushed byte.
// RULE_19: program counter is past both bytes when pushed and retained.
`default_nettype none
module abcx_core
  import abcx_pkg::*;
#(
  parameter int MC_CLKS = MC_CLKS_DEF
) (
  input  wire logic           clk,
  input  wire logic           sys_rst,
  output logic                code_rd_q,
  output logic         [15:0] code_addr_q,
  input  wire logic    [7:0]  code_data,
  input  wire logic           code_valid,
  output logic                data_req_q,
  output logic                data_we_q,
  output logic                data_space_q,
  output logic         [7:0]  data_addr_q,
  output logic         [7:0]  data_wdata_q,
  input  wire logic    [7:0]  data_rdata,
  input  wire logic           data_ack,
  output logic         [7:0]  acc_q,
  output abcx_psw_t           psw_q,
  output logic         [7:0]  sp_q,
  output abcx_arg_view_t      arg_view_q,
  output logic                instr_done_q,
  output logic                illegal_q
);
  localparam int DIVW = (MC_CLKS > 1) ? $clog2(MC_CLKS) : 1;
  localparam logic [DIVW-1:0] DIV_LAST = DIVW'(MC_CLKS - 1);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef enum logic [6:0] {
    ST_FETCH_OP  = 7'h01,
    ST_FETCH_ARG = 7'h02,
    ST_RD_PTR    = 7'h04,
    ST_RD_OPND   = 7'h08,
    ST_PUSH_LO   = 7'h10,
    ST_PUSH_HI   = 7'h20,
    ST_WAIT      = 7'h40
  } abcx_st_t;

  typedef struct packed {
    abcx_st_t       st;
    logic [15:0]    pc;
    logic [7:0]     op;
    logic [7:0]     arg;
    logic [7:0]     acc;
    abcx_psw_t      psw;
    logic [7:0]     sp;
    logic [DIVW-1:0] div;
    logic [1:0]     elapsed;
    logic [1:0]     need;
    logic           code_rd;
    logic           data_req;
    logic           data_we;
    logic           data_space;
    logic [7:0]     data_addr;
    logic [7:0]     data_wdata;
    abcx_arg_view_t view;
    logic           done;
    logic           illegal;
  } abcx_state_t;

  abcx_state_t s_q;
  abcx_state_t s_d;

  logic [7:0] alu_b;
  logic [7:0] alu_sum;
  logic       alu_cy;
  logic       alu_aux;
  logic       alu_ovf;
  logic       tick;
  logic [7:0] reg_addr;

  // ---------------------------------------------------------------
  // adder
  // ---------------------------------------------------------------
  // RULE_05: short immediate straight off the code bus, others from data port
  assign alu_b    = (s_q.st == ST_FETCH_ARG) ? code_data : data_rdata;
  assign tick     = (s_q.div == DIV_LAST);
  assign reg_addr = {3'h0, s_q.psw.bank, code_data[2:0]};

  abcx_add_unit u_add (
    .a          (s_q.acc),
    .b          (alu_b),
    .cin        (s_q.psw.cy),
    .with_carry (s_q.op[CARRY_SEL_BIT]),
    .sum        (alu_sum),
    .cy         (alu_cy),
    .aux        (alu_aux),
    .ovf        (alu_ovf)
  );

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    s_d         = s_q;
    s_d.done    = 1'b0;
    s_d.illegal = 1'b0;
    // RULE_01: machine cycle pacing
    s_d.div     = tick ? '0 : DIVW'(s_q.div + 1'b1);
    if (tick && s_q.elapsed != ELAPSED_MAX) begin
      s_d.elapsed = 2'(s_q.elapsed + 1'b1);
    end
    case (s_q.st)
      ST_FETCH_OP: begin
        if (code_valid) begin
          s_d.op      = code_data;
          s_d.pc      = 16'(s_q.pc + 1'b1);
          s_d.div     = '0;
          s_d.elapsed = 2'h0;
          // RULE_06: page call / jump decode
          if (is_page_call(code_data) || is_page_jump(code_data)) begin
            s_d.need = PAGE_CYCLES;
            s_d.st   = ST_FETCH_ARG;
          // RULE_15: add family operand form
          end else if (is_add(code_data)) begin
            s_d.need = ADD_CYCLES;
            if (code_data[3:0] == FORM_IMM || code_data[3:0] == FORM_DIRECT) begin
              s_d.st = ST_FETCH_ARG;
            end else if (code_data[3:1] == FORM_IND_HI3) begin
              s_d.st        = ST_RD_PTR;
              s_d.data_addr = {3'h0, s_q.psw.bank, 2'h0, code_data[0]};
              s_d.data_space = 1'b0;
            end else begin
              s_d.st        = ST_RD_OPND;
              s_d.data_addr = reg_addr;
              s_d.data_space = 1'b0;
            end
          end else begin
            // outside this decoder: retired as a one-byte no-op
            s_d.need    = OTHER_CYCLES;
            s_d.illegal = 1'b1;
            s_d.st      = ST_WAIT;
          end
        end
      end
      ST_FETCH_ARG: begin
        if (code_valid) begin
          s_d.arg = code_data;
          // RULE_19: pc moves past the second byte here
          s_d.pc  = 16'(s_q.pc + 1'b1);
          // RULE_03: direct space select
          s_d.view.special_function_space = direct_is_special(code_data);
          // RULE_02: bit selector split
          s_d.view.bit_byte = bit_byte_of(code_data);
          s_d.view.bit_pos  = code_data[2:0];
          // RULE_04: signed displacement
          s_d.view.rel_target = rel_target(16'(s_q.pc + 1'b1), code_data);
          if (is_page_call(s_q.op)) begin
            // RULE_18: pre-increment stack pointer
            s_d.sp         = 8'(s_q.sp + 1'b1);
            s_d.data_addr  = 8'(s_q.sp + 1'b1);
            s_d.data_space = 1'b0;
            // RULE_07: low byte first
            s_d.data_wdata = s_d.pc[7:0];
            s_d.st         = ST_PUSH_LO;
          end else if (is_page_jump(s_q.op)) begin
            // RULE_17: same target, no push
            s_d.pc = page_target_address(s_d.pc, s_q.op, code_data);
            s_d.st = ST_WAIT;
          end else if (s_q.op[3:0] == FORM_IMM) begin
            // RULE_10: sum into accumulator
            s_d.acc                      = alu_sum;
            s_d.psw.cy                   = alu_cy;
            s_d.psw.auxiliary_carry_flag = alu_aux;
            s_d.psw.signed_overflow_flag = alu_ovf;
            s_d.st                       = ST_WAIT;
          end else begin
            s_d.data_addr  = code_data;
            s_d.data_space = direct_is_special(code_data);
            s_d.st        = ST_RD_OPND;
          end
        end
      end
      ST_RD_PTR: begin
        if (data_ack) begin
          // indirect targets are always internal memory
          s_d.data_addr  = data_rdata;
          s_d.data_space = 1'b0;
          s_d.st        = ST_RD_OPND;
        end
      end
      ST_RD_OPND: begin
        if (data_ack) begin
          // RULE_16: only carry, auxiliary and overflow written
          s_d.acc                      = alu_sum;
          s_d.psw.cy                   = alu_cy;
          s_d.psw.auxiliary_carry_flag = alu_aux;
          s_d.psw.signed_overflow_flag = alu_ovf;
          s_d.st                       = ST_WAIT;
        end
      end
      ST_PUSH_LO: begin
        if (data_ack) begin
          // RULE_18: increment again before high byte
          s_d.sp         = 8'(s_q.sp + 1'b1);
          s_d.data_addr  = 8'(s_q.sp + 1'b1);
          s_d.data_wdata = s_q.pc[15:8];
          s_d.st         = ST_PUSH_HI;
        end
      end
      ST_PUSH_HI: begin
        if (data_ack) begin
          // RULE_08: redirect only after both bytes
          // RULE_09: upper five bits retained
          s_d.pc = page_target_address(s_q.pc, s_q.op, s_q.arg);
          s_d.st = ST_WAIT;
        end
      end
      ST_WAIT: begin
        // RULE_06: hold until the listed machine cycles have elapsed
        if (s_q.elapsed >= s_q.need) begin
          s_d.done = 1'b1;
          s_d.st   = ST_FETCH_OP;
        end
      end
      default: begin
        s_d.st = ST_FETCH_OP;
      end
    endcase
    s_d.code_rd  = (s_d.st == ST_FETCH_OP) || (s_d.st == ST_FETCH_ARG);
    s_d.data_req = (s_d.st == ST_RD_PTR) || (s_d.st == ST_RD_OPND) ||
                   (s_d.st == ST_PUSH_LO) || (s_d.st == ST_PUSH_HI);
    s_d.data_we  = (s_d.st == ST_PUSH_LO) || (s_d.st == ST_PUSH_HI);
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_q         <= '0;
      s_q.st      <= ST_FETCH_OP;
      s_q.pc      <= PC_RESET;
      s_q.sp      <= SP_RESET;
      s_q.acc     <= ACC_RESET;
      s_q.psw     <= PSW_RESET;
      s_q.code_rd <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign code_rd_q    = s_q.code_rd;
  assign code_addr_q  = s_q.pc;
  assign data_req_q   = s_q.data_req;
  assign data_we_q    = s_q.data_we;
  assign data_space_q = s_q.data_space;
  assign data_addr_q  = s_q.data_addr;
  assign data_wdata_q = s_q.data_wdata;
  assign acc_q        = s_q.acc;
  assign psw_q        = s_q.psw;
  assign sp_q         = s_q.sp;
  assign arg_view_q   = s_q.view;
  assign instr_done_q = s_q.done;
  assign illegal_q    = s_q.illegal;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  logic [8:0] ref_sum;
  logic [4:0] ref_lo;
  logic       ref_cin;
  logic       add_now;

  assign ref_cin = s_q.op[CARRY_SEL_BIT] & s_q.psw.cy;
  assign ref_sum = {1'b0, s_q.acc} + {1'b0, alu_b} + {8'h00, ref_cin};
  assign ref_lo  = {1'b0, s_q.acc[3:0]} + {1'b0, alu_b[3:0]} + {4'h0, ref_cin};
  assign add_now = (s_q.st == ST_RD_OPND && data_ack) ||
                   (s_q.st == ST_FETCH_ARG && code_valid && is_add(s_q.op) &&
                    s_q.op[3:0] == FORM_IMM);

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_add_sum_carry: assert property ( // RULE_12
    add_now |=> acc_q == $past(ref_sum[7:0]) && psw_q.cy == $past(ref_sum[8]))
    else $error("add result or carry wrong");
  a_add_aux: assert property ( // RULE_13
    add_now |=> psw_q.auxiliary_carry_flag == $past(ref_lo[4]))
    else $error("auxiliary carry wrong");
  a_add_overflow: assert property ( // RULE_14
    add_now |=> psw_q.signed_overflow_flag ==
      $past((s_q.acc[7] == alu_b[7]) && (ref_sum[7] != s_q.acc[7])))
    else $error("overflow wrong");
  a_add_keeps_other: assert property ( // RULE_16
    add_now |=> psw_q.bank == $past(psw_q.bank) && psw_q.f0 == $past(psw_q.f0))
    else $error("unlisted flag changed");
  a_push_sp_pre: assert property ( // RULE_18
    s_q.st == ST_FETCH_ARG && code_valid && is_page_call(s_q.op)
      |=> sp_q == 8'($past(sp_q) + 1'b1) && data_addr_q == sp_q && data_we_q)
    else $error("push slot not pre-incremented");
  a_push_order: assert property ( // RULE_07
    s_q.st == ST_PUSH_LO && data_ack
      |-> data_wdata_q == code_addr_q[7:0] ##1 data_wdata_q == code_addr_q[15:8])
    else $error("return address push order wrong");
  a_call_target: assert property ( // RULE_08
    s_q.st == ST_PUSH_HI && data_ack |=> code_addr_q ==
      {$past(code_addr_q[15:11]), $past(s_q.op[7:5]), $past(s_q.arg)})
    else $error("page call target wrong");
  a_call_no_flags: assert property ( // RULE_06
    s_q.st == ST_PUSH_LO |-> ##1 $stable(psw_q) && $stable(acc_q))
    else $error("page call touched flags");
  a_jump_no_push: assert property ( // RULE_17
    s_q.st == ST_FETCH_ARG && code_valid && is_page_jump(s_q.op)
      |=> !data_req_q [*2])
    else $error("page jump pushed");
  a_direct_space: assert property ( // RULE_03
    s_q.st == ST_FETCH_ARG && code_valid
      |=> arg_view_q.special_function_space == $past(code_data[SPACE_BIT]))
    else $error("direct space select wrong");
  a_page_cycles: assert property ( // RULE_06
    s_q.st == ST_FETCH_OP && code_valid && is_page_call(code_data) |=> !instr_done_q [*3])
    else $error("page call retired early");

  c_call: cover property (s_q.st == ST_PUSH_HI && data_ack);
  c_jump: cover property (s_q.st == ST_FETCH_ARG && code_valid && is_page_jump(s_q.op));
  c_carry_ovf: cover property (add_now && s_q.op[CARRY_SEL_BIT] ##1 psw_q.signed_overflow_flag);
  c_indirect: cover property (s_q.st == ST_RD_PTR && data_ack);

endmodule
`default_nettype wire

// ---- bench/abcx_mem_model.sv ----
`default_nettype none
module abcx_mem_model (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [1:0]  slow,
  input  wire logic        code_rd_q,
  input  wire logic [15:0] code_addr_q,
  output logic      [7:0]  code_data,
  output logic             code_valid,
  input  wire logic        data_req_q,
  input  wire logic        data_we_q,
  input  wire logic        data_space_q,
  input  wire logic [7:0]  data_addr_q,
  input  wire logic [7:0]  data_wdata_q,
  output logic      [7:0]  data_rdata,
  output logic             data_ack
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [7:0]  code_mem [0:65535];
  logic [7:0]  data_mem [0:511];
  int unsigned code_wait;
  int unsigned data_wait;

  initial begin
    code_valid = 1'b0;
    code_data  = 8'h00;
    data_ack   = 1'b0;
    data_rdata = 8'h00;
  end

  // ---------------------------------------------------------------
  // code port
  // ---------------------------------------------------------------
  // an offer lasts one cycle; while idle the bus toggles so a stale byte never matches
  always @(posedge clk) begin
    if (rst || !code_rd_q || code_valid) begin
      code_valid <= 1'b0;
      code_wait  <= 0;
      code_data  <= ~code_data;
    end else if (code_wait >= slow) begin
      code_valid <= 1'b1;
      code_data  <= code_mem[code_addr_q];
    end else begin
      code_wait <= code_wait + 1;
      code_data <= ~code_data;
    end
  end

  // ---------------------------------------------------------------
  // data port
  // ---------------------------------------------------------------
  always @(posedge clk) begin
    if (rst || !data_req_q || data_ack) begin
      data_ack   <= 1'b0;
      data_wait  <= 0;
      data_rdata <= ~data_rdata;
    end else if (data_wait >= slow) begin
      data_ack <= 1'b1;
      if (data_we_q) begin
        data_mem[{data_space_q, data_addr_q}] <= data_wdata_q;
      end else begin
        data_rdata <= data_mem[{data_space_q, data_addr_q}];
      end
    end else begin
      data_wait  <= data_wait + 1;
      data_rdata <= ~data_rdata;
    end
  end
endmodule
`default_nettype wire

// ---- bench/tb_top.sv ----
`default_nettype none
module tb_top import abcx_pkg::*; ();
  timeunit 1ns;
  timeprecision 1ns;

  typedef struct packed {
    logic [7:0]  op;
    logic [7:0]  arg;
    logic [7:0]  val;
    logic [10:0] exp;
  } abcx_tb_row_t;

  logic           clk;
  logic           sys_rst;
  logic [1:0]     slow;
  logic           code_rd_q;
  logic [15:0]    code_addr_q;
  logic [7:0]     code_data;
  logic           code_valid;
  logic           data_req_q;
  logic           data_we_q;
  logic           data_space_q;
  logic [7:0]     data_addr_q;
  logic [7:0]     data_wdata_q;
  logic [7:0]     data_rdata;
  logic           data_ack;
  logic [7:0]     acc_q;
  abcx_psw_t      psw_q;
  logic [7:0]     sp_q;
  abcx_arg_view_t arg_view_q;
  logic           instr_done_q;
  logic           illegal_q;
  int             miscompares = 0;
  int             checks = 0;
  int             cycles = 0;
  abcx_tb_row_t   rows [0:23];

  abcx_core #(.MC_CLKS(2)) u_abcx_core (
    .clk(clk), .sys_rst(sys_rst), .code_rd_q(code_rd_q), .code_addr_q(code_addr_q),
    .code_data(code_data), .code_valid(code_valid), .data_req_q(data_req_q),
    .data_we_q(data_we_q), .data_space_q(data_space_q), .data_addr_q(data_addr_q),
    .data_wdata_q(data_wdata_q), .data_rdata(data_rdata), .data_ack(data_ack),
    .acc_q(acc_q), .psw_q(psw_q), .sp_q(sp_q), .arg_view_q(arg_view_q),
    .instr_done_q(instr_done_q), .illegal_q(illegal_q));

  abcx_mem_model u_abcx_mem_model (
    .clk(clk), .rst(sys_rst), .slow(slow), .code_rd_q(code_rd_q),
    .code_addr_q(code_addr_q), .code_data(code_data), .code_valid(code_valid),
    .data_req_q(data_req_q), .data_we_q(data_we_q), .data_space_q(data_space_q),
    .data_addr_q(data_addr_q), .data_wdata_q(data_wdata_q), .data_rdata(data_rdata),
    .data_ack(data_ack));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic print_verdict();
    if (miscompares == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      print_verdict();
    end
  end

  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  // bounded wait for the retire pulse, or for the refusal pulse when want_illegal is set
  task automatic wait_done(input bit want_illegal);
    for (int i = 0; i < 200; i++) begin
      @(posedge clk);
      #10;
      if ((want_illegal ? illegal_q : instr_done_q) === 1'b1) return;
    end
    check("retire", 16'h0001, 16'h0000);
  endtask

  task automatic next_fetch(input logic [15:0] exp);
    for (int i = 0; i < 200; i++) begin
      if (code_rd_q === 1'b1 && code_valid === 1'b1) break;
      @(posedge clk);
      #10;
    end
    check("fetch", exp, code_addr_q);
  endtask

  // reference sum: {cy, aux, ov, sum}
  function automatic logic [10:0] add_ref(input logic [7:0] a, input logic [7:0] b,
                                          input logic c);
    logic [8:0] s;
    logic [4:0] lo;
    logic [7:0] s6;
    s  = {1'b0, a} + {1'b0, b} + 9'(c);
    lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + 5'(c);
    s6 = {1'b0, a[6:0]} + {1'b0, b[6:0]} + 8'(c);
    return {s[8], lo[4], s[8] ^ s6[7], s[7:0]};
  endfunction

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    int          pc;
    int          jpc;
    logic [7:0]  op;
    logic [7:0]  arg;
    logic [7:0]  val;
    logic [7:0]  acc_e;
    logic [10:0] res;
    abcx_psw_t   psw_e;
    sys_rst = 1'b1;
    slow    = 2'h0;
    for (int n = 0; n < 8; n++) u_abcx_mem_model.data_mem[n] = 8'(8'h59 + 8'h2E * n);
    u_abcx_mem_model.data_mem[9'h059] = 8'hC8;
    u_abcx_mem_model.data_mem[9'h087] = 8'h3C;
    u_abcx_mem_model.data_mem[9'h030] = 8'hF0;
    u_abcx_mem_model.data_mem[9'h190] = 8'h0F;
    pc = 0;
    acc_e = 8'h00;
    psw_e = '0;
    for (int k = 0; k < 24; k++) begin
      op  = (k < 12) ? 8'(8'h24 + k) : 8'(8'h34 + k - 12);
      arg = 8'h00;
      case (op[3:0])
        4'h4: begin
          arg = (k < 12) ? 8'h8B : 8'h75;
          val = arg;
        end
        4'h5: begin
          arg = (k < 12) ? 8'h30 : 8'h90;
          val = (k < 12) ? 8'hF0 : 8'h0F;
        end
        4'h6: val = 8'hC8;
        4'h7: val = 8'h3C;
        default: val = 8'(8'h59 + 8'h2E * (op[3:0] - 4'h8));
      endcase
      // expected chain, carry form adds the previous carry
      res   = add_ref(acc_e, val, op[4] & psw_e.cy);
      acc_e = res[7:0];
      psw_e.cy                   = res[10];
      psw_e.auxiliary_carry_flag = res[9];
      psw_e.signed_overflow_flag = res[8];
      rows[k] = '{op, arg, val, res};
      u_abcx_mem_model.code_mem[pc] = op;
      if (op[3:0] < 4'h6) u_abcx_mem_model.code_mem[pc + 1] = arg;
      pc += (op[3:0] < 4'h6) ? 2 : 1;
    end
    jpc = pc;
    u_abcx_mem_model.code_mem[jpc]      = 8'hE1;
    u_abcx_mem_model.code_mem[jpc + 1]  = 8'hFE;
    u_abcx_mem_model.code_mem[16'h07FE] = 8'hF1;
    u_abcx_mem_model.code_mem[16'h07FF] = 8'h34;
    u_abcx_mem_model.code_mem[16'h0F34] = 8'h01;
    u_abcx_mem_model.code_mem[16'h0F35] = 8'h10;
    u_abcx_mem_model.code_mem[16'h0810] = 8'hA5;
    repeat (8) @(posedge clk);
    #10;
    check("sp", 16'h0007, 16'(sp_q));
    check("acc", 16'h0000, 16'(acc_q));
    check("fetch", 16'h0000, code_addr_q);
    sys_rst = 1'b0;
    for (int k = 0; k < 24; k++) begin
      wait_done(1'b0);
      check("acc", 16'(rows[k].exp[7:0]), 16'(acc_q));
      check("psw", 16'({rows[k].exp[10:9], 3'h0, rows[k].exp[8], 2'h0}), 16'(psw_q));
      if (rows[k].op[3:0] == 4'h5) begin
        check("space", 16'(rows[k].arg[7]), 16'(arg_view_q.special_function_space));
      end
    end
    check("source", 16'h00F0, 16'(u_abcx_mem_model.data_mem[9'h030]));
    wait_done(1'b0);
    check("rel", 16'(jpc), arg_view_q.rel_target);
    check("bitbyte", 16'h00F8, 16'(arg_view_q.bit_byte));
    check("bitpos", 16'h0006, 16'(arg_view_q.bit_pos));
    next_fetch(16'h07FE);
    slow = 2'h2;
    wait_done(1'b0);
    check("sp", 16'h0009, 16'(sp_q));
    check("push_lo", 16'h0000, 16'(u_abcx_mem_model.data_mem[9'h008]));
    check("push_hi", 16'h0008, 16'(u_abcx_mem_model.data_mem[9'h009]));
    check("psw", 16'(psw_e), 16'(psw_q));
    next_fetch(16'h0F34);
    wait_done(1'b0);
    check("sp", 16'h0009, 16'(sp_q));
    next_fetch(16'h0810);
    wait_done(1'b1);
    check("acc", 16'(acc_e), 16'(acc_q));
    check("psw", 16'(psw_e), 16'(psw_q));
    sys_rst = 1'b1;
    repeat (2) @(posedge clk);
    #10;
    check("sp", 16'h0007, 16'(sp_q));
    check("acc", 16'h0000, 16'(acc_q));
    check("fetch", 16'h0000, code_addr_q);
    print_verdict();
  end
endmodule
`default_nettype wire
